// ### rtl/ggt_pkg.sv
package ggt_pkg;
    // register offsets
    localparam logic [7:0] GGT_OFS_RX_FINE_GAIN   = 8'h29;
    localparam logic [7:0] GGT_OFS_LINK_FORMAT    = 8'h2a;
    localparam logic [7:0] GGT_OFS_THRESHOLD      = 8'h2b;
    localparam logic [7:0] GGT_OFS_IRQ_CONTROL    = 8'h2c;
    localparam logic [7:0] GGT_OFS_GLOBAL_CONTROL = 8'h2d;
    // reset values
    localparam logic [7:0] GGT_RST_RX_FINE_GAIN = 8'h00;
    localparam logic [7:0] GGT_RST_LINK_FORMAT  = 8'h03;
    localparam logic [7:0] GGT_RST_THRESHOLD    = 8'h00;
    localparam logic [3:0] GGT_RST_IRQ_CONTROL  = 4'h0;
    // field positions
    localparam int GGT_BIT_GAIN_SIGN = 4;
    localparam int GGT_BIT_FMT_LO    = 2;
    localparam int GGT_BIT_B2_EN     = 1;
    localparam int GGT_BIT_B1_EN     = 0;
    localparam int GGT_BIT_FLAG      = 3;
    localparam int GGT_BIT_SOURCE    = 2;
    localparam int GGT_BIT_MASK      = 1;
    localparam int GGT_BIT_POLARITY  = 0;
    localparam int GGT_BIT_GLOBAL_EN = 0;
    // sample codings on the voice link
    typedef enum logic [1:0] {
        GGT_FMT_ALAW,
        GGT_FMT_MULAW,
        GGT_FMT_LIN8,
        GGT_FMT_LIN16
    } ggt_fmt_t;
endpackage : ggt_pkg

// ### rtl/ggt_regs.sv
// Functional notes
// - sign bit clear raises gain with step, set raises attenuation.
// - each step count is 0.1 dB; step zero applies no change.
// - fine adjustment reaches at most 1.5 dB either way.
// - format field selects A-law, mu-law, 8-bit linear or 16-bit linear.
// - 8-bit linear carries upper eight bits of the 16-bit sample.
// - 16-bit linear uses both slots for each sample, both directions; this block maps transmit samples only.
// - second slot carries data only while its enable bit is set.
// - first slot carries data only while its enable bit is set.
// - 16-bit linear without second slot sends upper byte in first slot.
// - 16-bit linear without first slot sends lower byte in second slot.
// - eight-bit threshold register holds the comparison level.
// - source bit picks loop current when clear, line voltage when set.
// - absolute value compared; polarity clear below, set above threshold.
// - trigger sets sticky event flag until software writes zero.
// - interrupt asserts only with flag, mask and global enable all set.
// - mask clear keeps interrupt low though the flag still records.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ggt_regs #(
    parameter int MEAS_W = 16
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output var  logic [7:0]        reg_rdata,
    // measurements, signed, one valid pulse each
    input  wire logic [MEAS_W-1:0] loop_current_reading,
    input  wire logic              loop_current_valid,
    input  wire logic [MEAS_W-1:0] line_voltage_reading,
    input  wire logic              line_voltage_valid,
    // voice samples, 16-bit linear internal
    input  wire logic [15:0]       tx_sample,
    input  wire logic              tx_sample_valid,
    // configuration outputs
    output var  logic              rx_fine_gain_sign,
    output var  logic [3:0]        rx_fine_gain_step,
    output var  logic [4:0]        rx_gain_db_tenths,
    output var  logic              rx_gain_is_atten,
    output var  ggt_pkg::ggt_fmt_t voice_sample_format,
    // per-slot byte to the voice link
    output var  logic [7:0]        first_slot_byte,
    output var  logic              first_slot_valid,
    output var  logic [7:0]        second_slot_byte,
    output var  logic              second_slot_valid,
    // interrupt
    output var  logic              shared_irq_output
);
    import ggt_pkg::*;

    logic [7:0]  gain_ff;
    logic [3:0]  fmt_ff;
    logic [7:0]  thresh_ff;
    logic [3:0]  ctl_ff;
    logic        global_en_ff;
    logic        trigger;
    logic [MEAS_W-1:0] sel_val;
    logic [MEAS_W-1:0] abs_val;
    logic        sel_valid;
    logic        hit;

    wire wr_gain   = reg_wr && reg_addr == GGT_OFS_RX_FINE_GAIN;
    wire wr_fmt    = reg_wr && reg_addr == GGT_OFS_LINK_FORMAT;
    wire wr_thresh = reg_wr && reg_addr == GGT_OFS_THRESHOLD;
    wire wr_ctl    = reg_wr && reg_addr == GGT_OFS_IRQ_CONTROL;
    wire wr_glob   = reg_wr && reg_addr == GGT_OFS_GLOBAL_CONTROL;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gain_ff <= GGT_RST_RX_FINE_GAIN;
        end else if (wr_gain) begin
            gain_ff <= {3'h0, reg_wdata[4:0]};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fmt_ff <= GGT_RST_LINK_FORMAT[3:0];
        end else if (wr_fmt) begin
            fmt_ff <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            thresh_ff <= GGT_RST_THRESHOLD;
        end else if (wr_thresh) begin
            thresh_ff <= reg_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            global_en_ff <= 1'b0;
        end else if (wr_glob) begin
            global_en_ff <= reg_wdata[GGT_BIT_GLOBAL_EN];
        end
    end

    // comparator input
    always_comb begin
        sel_val   = ctl_ff[GGT_BIT_SOURCE] ? line_voltage_reading : loop_current_reading;
        sel_valid = ctl_ff[GGT_BIT_SOURCE] ? line_voltage_valid : loop_current_valid;
        // most negative value saturates rather than wrapping
        if (sel_val[MEAS_W-1]) begin
            abs_val = (sel_val == {1'b1, {(MEAS_W-1){1'b0}}}) ? {1'b0, {(MEAS_W-1){1'b1}}} : -sel_val;
        end else begin
            abs_val = sel_val;
        end
        if (ctl_ff[GGT_BIT_POLARITY]) begin
            hit = abs_val > MEAS_W'(thresh_ff);
        end else begin
            hit = abs_val < MEAS_W'(thresh_ff);
        end
        trigger = sel_valid && hit;
    end

    // control bits; flag: hardware set wins over a clearing write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_ff <= GGT_RST_IRQ_CONTROL;
        end else begin
            if (wr_ctl) begin
                ctl_ff[2:0] <= reg_wdata[2:0];
            end
            if (trigger) begin
                ctl_ff[GGT_BIT_FLAG] <= 1'b1;
            end else if (wr_ctl && !reg_wdata[GGT_BIT_FLAG]) begin
                ctl_ff[GGT_BIT_FLAG] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shared_irq_output <= 1'b0;
        end else begin
            shared_irq_output <= ctl_ff[GGT_BIT_FLAG] && ctl_ff[GGT_BIT_MASK] && global_en_ff;
        end
    end

    // gain view: step 15 gives 1.5 dB at most
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_fine_gain_sign <= 1'b0;
            rx_fine_gain_step <= 4'h0;
            rx_gain_db_tenths <= 5'h00;
            rx_gain_is_atten  <= 1'b0;
        end else begin
            rx_fine_gain_sign <= gain_ff[GGT_BIT_GAIN_SIGN];
            rx_fine_gain_step <= gain_ff[3:0];
            rx_gain_db_tenths <= {1'b0, gain_ff[3:0]};
            rx_gain_is_atten  <= gain_ff[GGT_BIT_GAIN_SIGN] && gain_ff[3:0] != 4'h0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            voice_sample_format <= GGT_FMT_ALAW;
        end else begin
            voice_sample_format <= ggt_fmt_t'(fmt_ff[3:2]);
        end
    end

    // slot mapping; companding itself lives in the codec path
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            first_slot_byte   <= 8'h00;
            first_slot_valid  <= 1'b0;
            second_slot_byte  <= 8'h00;
            second_slot_valid <= 1'b0;
        end else begin
            first_slot_valid  <= 1'b0;
            second_slot_valid <= 1'b0;
            if (tx_sample_valid) begin
                if (ggt_fmt_t'(fmt_ff[3:2]) == GGT_FMT_LIN16) begin
                    first_slot_byte   <= tx_sample[15:8];
                    second_slot_byte  <= tx_sample[7:0];
                    first_slot_valid  <= fmt_ff[GGT_BIT_B1_EN];
                    second_slot_valid <= fmt_ff[GGT_BIT_B2_EN];
                end else begin
                    // upper byte; compressed formats share this byte lane
                    first_slot_byte   <= tx_sample[15:8];
                    second_slot_byte  <= tx_sample[15:8];
                    first_slot_valid  <= fmt_ff[GGT_BIT_B1_EN];
                    second_slot_valid <= fmt_ff[GGT_BIT_B2_EN];
                end
            end
        end
    end

    // read port, data in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == GGT_OFS_RX_FINE_GAIN) begin
                reg_rdata <= gain_ff;
            end else if (reg_addr == GGT_OFS_LINK_FORMAT) begin
                reg_rdata <= {4'h0, fmt_ff};
            end else if (reg_addr == GGT_OFS_THRESHOLD) begin
                reg_rdata <= thresh_ff;
            end else if (reg_addr == GGT_OFS_IRQ_CONTROL) begin
                reg_rdata <= {4'h0, ctl_ff};
            end else if (reg_addr == GGT_OFS_GLOBAL_CONTROL) begin
                reg_rdata <= {7'h00, global_en_ff};
            end else begin
                reg_rdata <= 8'h00;
            end
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    flag_sticky_a: assert property (@(posedge clk) disable iff (rst)
        ctl_ff[GGT_BIT_FLAG] && !(wr_ctl && !reg_wdata[GGT_BIT_FLAG]) |=> ctl_ff[GGT_BIT_FLAG])
        else $error("event flag dropped without a clearing write");
    flag_set_a: assert property (@(posedge clk) disable iff (rst)
        trigger |=> ctl_ff[GGT_BIT_FLAG])
        else $error("trigger did not set event flag");
    irq_gate_a: assert property (@(posedge clk) disable iff (rst)
        shared_irq_output |-> $past(ctl_ff[GGT_BIT_FLAG] && ctl_ff[GGT_BIT_MASK] && global_en_ff))
        else $error("interrupt without flag, mask and enable");
    irq_masked_a: assert property (@(posedge clk) disable iff (rst)
        !ctl_ff[GGT_BIT_MASK] |=> !shared_irq_output)
        else $error("interrupt asserted while masked");
    polarity_a: assert property (@(posedge clk) disable iff (rst)
        sel_valid && !ctl_ff[GGT_BIT_POLARITY] && abs_val >= MEAS_W'(thresh_ff) |-> !trigger)
        else $error("below-threshold trigger at or above level");
    gain_max_a: assert property (@(posedge clk) disable iff (rst)
        rx_gain_db_tenths <= 5'h0f)
        else $error("fine gain beyond 1.5 dB");
    gain_zero_a: assert property (@(posedge clk) disable iff (rst)
        rx_fine_gain_step == 4'h0 |-> rx_gain_db_tenths == 5'h00 && !rx_gain_is_atten)
        else $error("step zero applied a change");
    slot_b2_a: assert property (@(posedge clk) disable iff (rst)
        second_slot_valid |-> $past(fmt_ff[GGT_BIT_B2_EN] && tx_sample_valid))
        else $error("second slot used while disabled");
    slot_b1_a: assert property (@(posedge clk) disable iff (rst)
        first_slot_valid |-> $past(fmt_ff[GGT_BIT_B1_EN] && tx_sample_valid))
        else $error("first slot used while disabled");
    read_zero_a: assert property (@(posedge clk) disable iff (rst)
        reg_rd && reg_addr == GGT_OFS_IRQ_CONTROL |=> reg_rdata[7:4] == 4'h0)
        else $error("reserved bits read nonzero");

    // register view
    atten_dir_a: assert property (@(posedge clk) disable iff (rst)
        gain_ff[GGT_BIT_GAIN_SIGN] && gain_ff[3:0] != 4'h0
        |=> rx_gain_is_atten)
        else $error("set sign with nonzero step not shown as attenuation");

    gain_dir_a: assert property (@(posedge clk) disable iff (rst)
        !gain_ff[GGT_BIT_GAIN_SIGN]
        |=> !rx_gain_is_atten)
        else $error("clear sign shown as attenuation");

    gain_hold_a: assert property (@(posedge clk) disable iff (rst)
        !wr_gain
        |=> $stable(gain_ff))
        else $error("gain register changed without a write");

    gain_step_a: assert property (@(posedge clk) disable iff (rst)
        1'b1
        |=> rx_gain_db_tenths == {1'b0, $past(gain_ff[3:0])})
        else $error("tenths of a dB do not follow the step field");

    step_copy_a: assert property (@(posedge clk) disable iff (rst)
        1'b1
        |=> rx_fine_gain_step == $past(gain_ff[3:0]))
        else $error("step output does not follow the register");

    gain_bits_a: assert property (@(posedge clk) disable iff (rst)
        1'b1
        |-> gain_ff[7:5] == 3'h0)
        else $error("reserved gain bits took a write");

    // voice link
    fmt_map_a: assert property (@(posedge clk) disable iff (rst)
        1'b1
        |=> voice_sample_format == ggt_fmt_t'($past(fmt_ff[3:2])))
        else $error("format output does not follow the field");

    fmt_hold_a: assert property (@(posedge clk) disable iff (rst)
        !wr_fmt
        |=> $stable(fmt_ff))
        else $error("format register changed without a write");

    lin8_byte_a: assert property (@(posedge clk) disable iff (rst)
        tx_sample_valid && fmt_ff[3:2] == 2'b10 && fmt_ff[GGT_BIT_B1_EN]
        |=> first_slot_valid && first_slot_byte == $past(tx_sample[15:8]))
        else $error("8-bit linear did not carry the upper byte");

    lin16_pair_a: assert property (@(posedge clk) disable iff (rst)
        tx_sample_valid && fmt_ff == 4'hf
        |=> first_slot_valid && second_slot_valid && second_slot_byte == $past(tx_sample[7:0]))
        else $error("16-bit linear did not use both slots");

    b1_only_a: assert property (@(posedge clk) disable iff (rst)
        tx_sample_valid && fmt_ff == 4'hd
        |=> !second_slot_valid && first_slot_valid && first_slot_byte == $past(tx_sample[15:8]))
        else $error("first slot alone did not carry the upper byte");

    b2_only_a: assert property (@(posedge clk) disable iff (rst)
        tx_sample_valid && fmt_ff == 4'he
        |=> !first_slot_valid && second_slot_valid && second_slot_byte == $past(tx_sample[7:0]))
        else $error("second slot alone did not carry the lower byte");

    fmt_read_a: assert property (@(posedge clk) disable iff (rst)
        reg_rd && reg_addr == GGT_OFS_LINK_FORMAT
        |=> reg_rdata[7:4] == 4'h0)
        else $error("reserved format bits read nonzero");

    // comparator, interrupt and unmapped reads
    thresh_hold_a: assert property (@(posedge clk) disable iff (rst)
        !wr_thresh
        |=> $stable(thresh_ff))
        else $error("threshold changed without a write");

    thresh_read_a: assert property (@(posedge clk) disable iff (rst)
        reg_rd && reg_addr == GGT_OFS_THRESHOLD
        |=> reg_rdata == $past(thresh_ff))
        else $error("threshold read back wrong");

    source_sel_a: assert property (@(posedge clk) disable iff (rst)
        (ctl_ff[GGT_BIT_SOURCE] ? !line_voltage_valid : !loop_current_valid)
        |-> !trigger)
        else $error("trigger from the unselected source");

    polarity_hi_a: assert property (@(posedge clk) disable iff (rst)
        sel_valid && ctl_ff[GGT_BIT_POLARITY] && abs_val <= MEAS_W'(thresh_ff)
        |-> !trigger)
        else $error("above-threshold trigger at or below level");

    flag_clear_a: assert property (@(posedge clk) disable iff (rst)
        wr_ctl && !reg_wdata[GGT_BIT_FLAG] && !trigger
        |=> !ctl_ff[GGT_BIT_FLAG])
        else $error("clearing write left the event flag set");

    irq_follow_a: assert property (@(posedge clk) disable iff (rst)
        ctl_ff[GGT_BIT_FLAG] && ctl_ff[GGT_BIT_MASK] && global_en_ff
        |=> shared_irq_output)
        else $error("interrupt missing with flag, mask and enable");

    irq_global_a: assert property (@(posedge clk) disable iff (rst)
        !global_en_ff
        |=> !shared_irq_output)
        else $error("interrupt with global enable clear");

    irq_noflag_a: assert property (@(posedge clk) disable iff (rst)
        !ctl_ff[GGT_BIT_FLAG]
        |=> !shared_irq_output)
        else $error("interrupt without the event flag");

    unmapped_rd_a: assert property (@(posedge clk) disable iff (rst)
        reg_rd && reg_addr > GGT_OFS_GLOBAL_CONTROL
        |=> reg_rdata == 8'h00)
        else $error("unmapped read returned nonzero");

    irq_seen_c: cover property (@(posedge clk) disable iff (rst) $rose(shared_irq_output));
    flag_clear_c: cover property (@(posedge clk) disable iff (rst) $fell(ctl_ff[GGT_BIT_FLAG]));
    lin16_c: cover property (@(posedge clk) disable iff (rst) first_slot_valid && second_slot_valid);
    set_clear_c: cover property (@(posedge clk) disable iff (rst)
        trigger && wr_ctl && !reg_wdata[GGT_BIT_FLAG]);
endmodule : ggt_regs
`default_nettype wire

// ### test/ggt_host.sv
`timescale 1ns/1ps
`default_nettype none
module ggt_host (
    // clock
    input  wire logic       clk,
    // register port
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    input  wire logic [7:0] reg_rdata
);
    import ggt_pkg::*;

    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // idle bus shows inverted last values so stale data never passes for fresh
    task automatic release_bus();
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        reg_addr  <= ~reg_addr;
        reg_wdata <= ~reg_wdata;
    endtask : release_bus

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        reg_addr  <= addr;
        reg_wdata <= data;
        reg_wr    <= 1'b1;
        @(posedge clk);
        release_bus();
    endtask : wr

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        reg_addr <= addr;
        reg_rd   <= 1'b1;
        @(posedge clk);
        release_bus();
        #1;
        data = reg_rdata;
    endtask : rd

    // after servicing, the host writes the event flag back to zero
    task automatic clear_flag(input logic [7:0] ctl);
        wr(GGT_OFS_IRQ_CONTROL, ctl & 8'hf7);
    endtask : clear_flag
endmodule : ggt_host
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ggt_pkg::*;
    typedef struct packed {
        logic [7:0] wd;
        logic [7:0] rb;
        logic [4:0] tenths;
        logic       atten;
    } ggt_row_t;

    logic clk = 1'b0, rst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, loop_current_valid = 1'b0, line_voltage_valid = 1'b0, tx_sample_valid = 1'b0;
    logic [15:0] loop_current_reading = 16'h0000, line_voltage_reading = 16'h0000, tx_sample = 16'h0000;
    logic rx_fine_gain_sign, rx_gain_is_atten, first_slot_valid, second_slot_valid, shared_irq_output;
    logic [3:0] rx_fine_gain_step;
    logic [4:0] rx_gain_db_tenths;
    logic [7:0] first_slot_byte, second_slot_byte;
    ggt_fmt_t   voice_sample_format;
    int n_fail = 0, checked = 0;
    ggt_row_t rows [4] = '{'{8'hff, 8'h1f, 5'd15, 1'b1}, '{8'h10, 8'h10, 5'd0, 1'b0},
                           '{8'h0f, 8'h0f, 5'd15, 1'b0}, '{8'h13, 8'h13, 5'd3, 1'b1}};
    logic [7:0] rst_tab [6] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] slot_ctl [4] = '{8'h0d, 8'h0e, 8'h0c, 8'h02};

    ggt_regs #(.MEAS_W(16)) i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loop_current_reading(loop_current_reading),
        .loop_current_valid(loop_current_valid), .line_voltage_reading(line_voltage_reading),
        .line_voltage_valid(line_voltage_valid), .tx_sample(tx_sample), .tx_sample_valid(tx_sample_valid),
        .rx_fine_gain_sign(rx_fine_gain_sign), .rx_fine_gain_step(rx_fine_gain_step),
        .rx_gain_db_tenths(rx_gain_db_tenths), .rx_gain_is_atten(rx_gain_is_atten),
        .voice_sample_format(voice_sample_format), .first_slot_byte(first_slot_byte),
        .first_slot_valid(first_slot_valid), .second_slot_byte(second_slot_byte),
        .second_slot_valid(second_slot_valid), .shared_irq_output(shared_irq_output));
    ggt_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    // one measurement pulse; both readings carry the value, only one is flagged valid
    task automatic meas(input logic volt, input logic [15:0] v);
        @(posedge clk);
        loop_current_reading <= v;
        line_voltage_reading <= v;
        loop_current_valid   <= !volt;
        line_voltage_valid   <= volt;
        @(posedge clk);
        loop_current_valid   <= 1'b0;
        line_voltage_valid   <= 1'b0;
        loop_current_reading <= ~v;
        line_voltage_reading <= ~v;
        repeat (2) @(posedge clk);
    endtask : meas

    task automatic sample(input logic [15:0] s);
        @(posedge clk);
        tx_sample       <= s;
        tx_sample_valid <= 1'b1;
        @(posedge clk);
        tx_sample_valid <= 1'b0;
        tx_sample       <= ~s;
        #1;
    endtask : sample

    task automatic irq_after(input logic exp);
        repeat (3) @(posedge clk);
        #1 chk(shared_irq_output, exp);
    endtask : irq_after

    initial begin
        #1000000;
        n_fail++;
        close_out();
    end

    initial begin
        logic [7:0] d;
        logic [1:0] fmt;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            i_host.rd(8'h29 + 8'(i), d);
            chk(d, rst_tab[i]);
        end
        foreach (rows[i]) begin
            i_host.wr(GGT_OFS_RX_FINE_GAIN, rows[i].wd);
            i_host.rd(GGT_OFS_RX_FINE_GAIN, d);
            chk(d, rows[i].rb);
            chk({rx_fine_gain_sign, rx_fine_gain_step}, rows[i].rb[4:0]);
            chk(rx_gain_db_tenths, rows[i].tenths);
            chk(rx_gain_is_atten, rows[i].atten);
        end
        for (int f = 0; f < 4; f++) begin
            fmt = 2'(f);
            i_host.wr(GGT_OFS_LINK_FORMAT, {4'hf, fmt, 2'b11});
            sample(16'h1234);
            chk(voice_sample_format, fmt);
            chk({first_slot_valid, first_slot_byte}, 9'h112);
            chk({second_slot_valid, second_slot_byte}, (f == 3) ? 9'h134 : 9'h112);
            i_host.rd(GGT_OFS_LINK_FORMAT, d);
            chk(d, {4'h0, fmt, 2'b11});
        end
        foreach (slot_ctl[i]) begin
            i_host.wr(GGT_OFS_LINK_FORMAT, slot_ctl[i]);
            sample(16'h1234);
            chk(first_slot_valid, slot_ctl[i][0]);
            chk(second_slot_valid, slot_ctl[i][1]);
            if (i == 0) chk(first_slot_byte, 8'h12);
            if (i == 1) chk(second_slot_byte, 8'h34);
        end
        i_host.wr(GGT_OFS_THRESHOLD, 8'h0a);
        i_host.rd(GGT_OFS_THRESHOLD, d);
        chk(d, 8'h0a);
        i_host.wr(GGT_OFS_GLOBAL_CONTROL, 8'h01);
        i_host.wr(GGT_OFS_IRQ_CONTROL, 8'h02);
        meas(1'b0, 16'd5);
        irq_after(1'b1);
        meas(1'b0, 16'd20);
        i_host.rd(GGT_OFS_IRQ_CONTROL, d);
        chk(d, 8'h0a);
        i_host.clear_flag(8'h02);
        irq_after(1'b0);
        meas(1'b0, 16'd10);
        i_host.rd(GGT_OFS_IRQ_CONTROL, d);
        chk(d, 8'h02);
        i_host.wr(GGT_OFS_IRQ_CONTROL, 8'h07);
        meas(1'b0, 16'hffec);
        i_host.rd(GGT_OFS_IRQ_CONTROL, d);
        chk(d, 8'h07);
        meas(1'b1, 16'hffec);
        i_host.rd(GGT_OFS_IRQ_CONTROL, d);
        chk(d, 8'h0f);
        irq_after(1'b1);
        i_host.clear_flag(8'h05);
        meas(1'b1, 16'hffec);
        i_host.rd(GGT_OFS_IRQ_CONTROL, d);
        chk(d, 8'h0d);
        irq_after(1'b0);
        i_host.wr(GGT_OFS_GLOBAL_CONTROL, 8'h00);
        i_host.wr(GGT_OFS_IRQ_CONTROL, 8'h0f);
        irq_after(1'b0);
        i_host.wr(GGT_OFS_GLOBAL_CONTROL, 8'h01);
        irq_after(1'b1);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        i_host.rd(GGT_OFS_IRQ_CONTROL, d);
        chk({shared_irq_output, d}, 9'h000);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
